// ===== hw/cadence_pkg.sv
// constants and carrier types for the dual envelope cadence detector
// assumes one 40 MHz clock and an 8-bit register port with 9-bit addresses
package cadence_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [8:0] ADDR_CONTROL     = 9'h010;
  localparam logic [8:0] ADDR_A_LOW       = 9'h011;
  localparam logic [8:0] ADDR_A_HIGH      = 9'h012;
  localparam logic [8:0] ADDR_A_CADENCE   = 9'h013;
  localparam logic [8:0] ADDR_B_LOW       = 9'h014;
  localparam logic [8:0] ADDR_B_HIGH      = 9'h015;
  localparam logic [8:0] ADDR_B_CADENCE   = 9'h016;
  localparam logic [8:0] ADDR_EVENT       = 9'h017;
  localparam logic [7:0] RESET_VALUE      = 8'h00;
  localparam int         ON_A_BIT         = 0;
  localparam int         ON_B_BIT         = 1;
  localparam int         POS_BIT          = 7;
  localparam logic [6:0] COUNT_MAX        = 7'h7F;
  localparam logic [6:0] MAG_ZERO         = 7'h00;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int         CLOCK_HZ         = 40_000_000;
  localparam int         TICK_MS          = 4;
  localparam int         TICK_CYCLES      = CLOCK_HZ / 1000 * TICK_MS;
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  typedef struct packed {
    logic       valid;
    logic [6:0] magnitude;
  } sample_t;
  typedef struct packed {
    logic [6:0] low;
    logic [6:0] high;
  } thresholds_t;
endpackage : cadence_pkg

// ===== hw/cadence_detector.sv
// one envelope detector with threshold crossings and cadence timing
// assumes a shared 4 ms tick pulse and a same-clock sample stream
`timescale 1ns/100ps
`default_nettype none
module cadence_detector (
  input  wire logic                     clock_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     on_in,
  input  wire logic                     tick_in,
  input  wire cadence_pkg::sample_t     sample_in,
  input  wire cadence_pkg::thresholds_t limits_in,
  output logic [7:0]                    result_out,
  output logic                          event_out
);
  import cadence_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ABOVE = 3'b010,
    ST_BELOW = 3'b100
  } pos_state_t;

  pos_state_t state_ff;
  pos_state_t nxt_state;
  logic [6:0] peak_ff;
  logic [6:0] count_ff;
  logic [6:0] nxt_count;
  logic       latch;
  logic       going_up;
  logic       going_down;

  // ****************************************************************
  // envelope: magnitude-only compare, bit 6 most significant
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !on_in) begin
      peak_ff <= MAG_ZERO;
    end else if (sample_in.valid) begin
      peak_ff <= sample_in.magnitude;
    end
  end

  assign going_up   = (peak_ff > limits_in.high) && (state_ff != ST_ABOVE);
  assign going_down = (peak_ff < limits_in.low)  && (state_ff != ST_BELOW);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  begin
        if (going_up) begin
          nxt_state = ST_ABOVE;
        end else if (going_down) begin
          nxt_state = ST_BELOW;
        end
      end
      ST_ABOVE: begin
        if (going_down) begin
          nxt_state = ST_BELOW;
        end
      end
      ST_BELOW: begin
        if (going_up) begin
          nxt_state = ST_ABOVE;
        end
      end
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !on_in) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // cadence count and result latch
  // ****************************************************************
  // opposite crossing from a known side, or saturation
  assign latch = ((state_ff == ST_ABOVE) && going_down)
              || ((state_ff == ST_BELOW) && going_up)
              || ((state_ff != ST_IDLE) && tick_in && (count_ff == COUNT_MAX));

  always_comb begin
    nxt_count = count_ff;
    if (latch || (state_ff == ST_IDLE)) begin
      nxt_count = MAG_ZERO;
    end else if (tick_in) begin
      nxt_count = count_ff + 7'h01;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !on_in) begin
      count_ff <= MAG_ZERO;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !on_in) begin
      result_out <= RESET_VALUE;
    end else if (latch) begin
      result_out <= {(nxt_state == ST_ABOVE), count_ff};
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !on_in) begin
      event_out <= 1'b0;
    end else begin
      event_out <= latch;
    end
  end
endmodule : cadence_detector
`default_nettype wire

// ===== hw/energy_detect_cadence.sv
// register port and two independent envelope cadence detectors
// assumes same-clock sample streams and one-cycle register strobes
`timescale 1ns/100ps
`default_nettype none
module energy_detect_cadence #(
  parameter int TICK_LEN = cadence_pkg::TICK_CYCLES // clock cycles per 4 ms tick
) (
  input  wire logic                 clock_in,
  input  wire logic                 rst_n_in,
  input  wire cadence_pkg::reg_req_t req_in,
  input  wire cadence_pkg::sample_t  sample_a_in,
  input  wire cadence_pkg::sample_t  sample_b_in,
  output logic [7:0]                rdata_out,
  output logic                      event_a_out,
  output logic                      event_b_out
);
  import cadence_pkg::*;

  logic [7:0]  control_ff;
  logic [6:0]  a_low_ff;
  logic [6:0]  a_high_ff;
  logic [6:0]  b_low_ff;
  logic [6:0]  b_high_ff;
  logic [1:0]  sticky_ff;
  logic [17:0] tick_cnt_ff;
  logic        tick;
  logic [7:0]  result_a;
  logic [7:0]  result_b;
  logic [7:0]  nxt_rdata;
  thresholds_t limits_a;
  thresholds_t limits_b;

  function automatic logic hit(input reg_req_t r, input logic [8:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // ****************************************************************
  // writable registers
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      control_ff <= RESET_VALUE;
    end else if (hit(req_in, ADDR_CONTROL)) begin
      control_ff <= req_in.wdata;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      a_low_ff  <= MAG_ZERO;
      a_high_ff <= MAG_ZERO;
      b_low_ff  <= MAG_ZERO;
      b_high_ff <= MAG_ZERO;
    end else begin
      if (hit(req_in, ADDR_A_LOW)) begin
        a_low_ff <= req_in.wdata[6:0];
      end
      if (hit(req_in, ADDR_A_HIGH)) begin
        a_high_ff <= req_in.wdata[6:0];
      end
      if (hit(req_in, ADDR_B_LOW)) begin
        b_low_ff <= req_in.wdata[6:0];
      end
      if (hit(req_in, ADDR_B_HIGH)) begin
        b_high_ff <= req_in.wdata[6:0];
      end
    end
  end

  // ****************************************************************
  // 4 ms tick
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || tick) begin
      tick_cnt_ff <= 18'h00000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 18'h00001;
    end
  end

  assign tick = (tick_cnt_ff == 18'(TICK_LEN - 1));

  // ****************************************************************
  // detectors
  // ****************************************************************
  assign limits_a = '{low: a_low_ff, high: a_high_ff};
  assign limits_b = '{low: b_low_ff, high: b_high_ff};

  cadence_detector u_det_a (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .on_in      (control_ff[ON_A_BIT]),
    .tick_in    (tick),
    .sample_in  (sample_a_in),
    .limits_in  (limits_a),
    .result_out (result_a),
    .event_out  (event_a_out)
  );

  cadence_detector u_det_b (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .on_in      (control_ff[ON_B_BIT]),
    .tick_in    (tick),
    .sample_in  (sample_b_in),
    .limits_in  (limits_b),
    .result_out (result_b),
    .event_out  (event_b_out)
  );

  // ****************************************************************
  // event flags: reading a cadence register clears its flag, a new event wins
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sticky_ff <= 2'b00;
    end else begin
      if (event_a_out) begin
        sticky_ff[0] <= 1'b1;
      end else if (req_in.rd && (req_in.addr == ADDR_A_CADENCE)) begin
        sticky_ff[0] <= 1'b0;
      end
      if (event_b_out) begin
        sticky_ff[1] <= 1'b1;
      end else if (req_in.rd && (req_in.addr == ADDR_B_CADENCE)) begin
        sticky_ff[1] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_comb begin
    nxt_rdata = RESET_VALUE;
    if (req_in.addr == ADDR_CONTROL) begin
      nxt_rdata = control_ff;
    end else if (req_in.addr == ADDR_A_LOW) begin
      nxt_rdata = {1'b0, a_low_ff};
    end else if (req_in.addr == ADDR_A_HIGH) begin
      nxt_rdata = {1'b0, a_high_ff};
    end else if (req_in.addr == ADDR_A_CADENCE) begin
      nxt_rdata = result_a;
    end else if (req_in.addr == ADDR_B_LOW) begin
      nxt_rdata = {1'b0, b_low_ff};
    end else if (req_in.addr == ADDR_B_HIGH) begin
      nxt_rdata = {1'b0, b_high_ff};
    end else if (req_in.addr == ADDR_B_CADENCE) begin
      nxt_rdata = result_b;
    end else if (req_in.addr == ADDR_EVENT) begin
      nxt_rdata = {6'h00, sticky_ff};
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rdata_out <= RESET_VALUE;
    end else if (req_in.rd) begin
      rdata_out <= nxt_rdata;
    end else begin
      rdata_out <= RESET_VALUE;
    end
  end
endmodule : energy_detect_cadence
`default_nettype wire

// ===== verif/cadence_props.sv
// checker on the top-level ports of the cadence block
// assumes the shared register map of cadence_pkg
`timescale 1ns/100ps
`default_nettype none
module cadence_props (
  input wire logic                  clock_in,
  input wire logic                  rst_n_in,
  input wire cadence_pkg::reg_req_t req_in,
  input wire cadence_pkg::sample_t  sample_a_in,
  input wire cadence_pkg::sample_t  sample_b_in,
  input wire logic [7:0]            rdata_out,
  input wire logic                  event_a_out,
  input wire logic                  event_b_out
);
  import cadence_pkg::*;
  logic [7:0] ctl_ff;
  logic [6:0] thr_ff [8];
  logic       thr_sel;
  logic [8:0] a;
  assign a = req_in.addr;
  assign thr_sel = a == ADDR_A_LOW || a == ADDR_A_HIGH || a == ADDR_B_LOW || a == ADDR_B_HIGH;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ctl_ff <= RESET_VALUE;
      thr_ff <= '{default: MAG_ZERO};
    end else if (req_in.wr && a == ADDR_CONTROL) begin
      ctl_ff <= req_in.wdata;
    end else if (req_in.wr && thr_sel) begin
      thr_ff[a[2:0]] <= req_in.wdata[6:0];
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence off_a_s; !ctl_ff[ON_A_BIT] [*3]; endsequence
  sequence off_b_s; !ctl_ff[ON_B_BIT] [*3]; endsequence
  property thr_p;
    logic [6:0] v;
    (req_in.rd && thr_sel, v = thr_ff[a[2:0]]) |=> rdata_out == {1'b0, v};
  endproperty
  read_idle_a: assert property (!req_in.rd |=> rdata_out == RESET_VALUE)
    else $error("read data outside a read cycle");
  unmapped_read_a: assert property ((req_in.rd && (a < ADDR_CONTROL || a > ADDR_EVENT))
    |=> rdata_out == RESET_VALUE) else $error("unmapped read not zero");
  thr_read_a: assert property (thr_p)
    else $error("threshold read back wrong");
  ctl_read_a: assert property (req_in.rd && a == ADDR_CONTROL |=> rdata_out == $past(ctl_ff))
    else $error("control read back wrong");
  a_quiet_a: assert property (off_a_s |-> !event_a_out)
    else $error("event from disabled detector a");
  b_quiet_a: assert property (off_b_s |-> !event_b_out)
    else $error("event from disabled detector b");
  a_held_a: assert property (off_a_s ##0 (req_in.rd && a == ADDR_A_CADENCE) |=> rdata_out == 0)
    else $error("disabled detector a result not zero");
  b_held_a: assert property (off_b_s ##0 (req_in.rd && a == ADDR_B_CADENCE) |=> rdata_out == 0)
    else $error("disabled detector b result not zero");
endmodule : cadence_props
bind energy_detect_cadence cadence_props props (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .req_in(req_in), .sample_a_in(sample_a_in), .sample_b_in(sample_b_in),
  .rdata_out(rdata_out), .event_a_out(event_a_out), .event_b_out(event_b_out));
`default_nettype wire

// ===== verif/pcm_source.sv
// sample source model feeding both detector channels
// assumes the bench sets levels and the sample spacing
`timescale 1ns/100ps
`default_nettype none
module pcm_source (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic [6:0]       level_a_in,
  input  wire logic [6:0]       level_b_in,
  input  wire logic [1:0]       gap_in,
  output var cadence_pkg::sample_t sample_a_out,
  output var cadence_pkg::sample_t sample_b_out
);
  import cadence_pkg::*;
  logic [1:0] wait_ff;
  logic       go;
  assign go = wait_ff == gap_in;
  always_ff @(posedge clock_in) begin
    wait_ff <= (!rst_n_in || go) ? 2'h0 : wait_ff + 2'h1;
    sample_a_out.valid <= rst_n_in && go;
    sample_b_out.valid <= rst_n_in && go;
    // between samples the lines carry a changing pattern
    sample_a_out.magnitude <= go ? level_a_in : ~sample_a_out.magnitude;
    sample_b_out.magnitude <= go ? level_b_in : ~sample_b_out.magnitude;
  end
endmodule : pcm_source
`default_nettype wire

// ===== verif/energy_detect_cadence_test.sv
// self-checking bench with a reference model of both detectors
// assumes pcm_source as sample supplier
`timescale 1ns/100ps
`default_nettype none
module energy_detect_cadence_test;
  import cadence_pkg::*;
  localparam logic [6:0] SEQ_A [8] = '{7'h00, 7'h3F, 7'h40, 7'h41, 7'h05, 7'h14, 7'h7F, 7'h13};
  localparam logic [6:0] SEQ_B [8] = '{7'h28, 7'h1E, 7'h09, 7'h1F, 7'h00, 7'h0A, 7'h7E, 7'h01};
  localparam int TICK_LEN = 20;
  localparam int RUN_CYCLES = 10000;
  logic       clock_in;
  logic       rst_n_in;
  reg_req_t   req;
  sample_t    sa;
  sample_t    sb;
  logic [7:0] rdata;
  logic       ev_a;
  logic       ev_b;
  logic [6:0] lvl [2];
  logic [1:0] gap;
  logic [7:0] v;
  logic [7:0] w;
  logic [7:0] ctl;
  integer     fails, n_checks, seed, cyc, i, j;
  integer     lo [2], hi [2], st [2], cnt [2], res [2], nev [2], seen [2];
  integer     env [2], pr [2], pn [2];
  logic [1:0] fl;
  logic [1:0] pf;
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  pcm_source src (.clock_in(clock_in), .rst_n_in(rst_n_in), .level_a_in(lvl[0]),
    .level_b_in(lvl[1]), .gap_in(gap), .sample_a_out(sa), .sample_b_out(sb));
  energy_detect_cadence #(.TICK_LEN(TICK_LEN)) DUT (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .req_in(req), .sample_a_in(sa), .sample_b_in(sb), .rdata_out(rdata), .event_a_out(ev_a),
    .event_b_out(ev_b));
  // envelope held one cycle, then compared; settings take effect the edge after
  task automatic step(input integer k, input sample_t s, input bit t);
    integer up, dn, nst, lat;
    if (!ctl[k]) begin
      {env[k], st[k], cnt[k], res[k]} = '0;
      return;
    end
    up = env[k] > hi[k] && st[k] != 1;
    dn = env[k] < lo[k] && st[k] != 2;
    nst = up ? 1 : dn ? 2 : st[k];
    lat = st[k] != 0 && (nst != st[k] || (t && cnt[k] == 127));
    if (lat) begin
      res[k] = (nst == 1 ? 128 : 0) + cnt[k];
      nev[k]++;
    end
    cnt[k] = (lat || st[k] == 0) ? 0 : cnt[k] + t;
    st[k] = nst;
    if (s.valid) env[k] = s.magnitude;
  endtask : step
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      cyc = 0;
      ctl = 8'h00;
      fl = 2'b00;
      for (j = 0; j < 2; j++) {lo[j], hi[j], st[j], cnt[j], res[j], nev[j], seen[j], env[j]} = '0;
    end else begin
      cyc++;
      pr = res;
      pn = nev;
      pf = fl;
      seen[0] += ev_a;
      seen[1] += ev_b;
      if (ev_a) fl[0] = 1'b1;
      else if (req.rd && req.addr == ADDR_A_CADENCE) fl[0] = 1'b0;
      if (ev_b) fl[1] = 1'b1;
      else if (req.rd && req.addr == ADDR_B_CADENCE) fl[1] = 1'b0;
      step(0, sa, cyc % TICK_LEN == 0);
      step(1, sb, cyc % TICK_LEN == 0);
      if (req.wr && req.addr == ADDR_CONTROL) ctl = req.wdata;
      if (req.wr && req.addr == ADDR_A_LOW) lo[0] = req.wdata[6:0];
      if (req.wr && req.addr == ADDR_A_HIGH) hi[0] = req.wdata[6:0];
      if (req.wr && req.addr == ADDR_B_LOW) lo[1] = req.wdata[6:0];
      if (req.wr && req.addr == ADDR_B_HIGH) hi[1] = req.wdata[6:0];
    end
  end
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task wr(input logic [8:0] ad, input logic [7:0] dat);
    @(posedge clock_in);
    req <= '{addr: ad, wdata: dat, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [8:0] ad, output logic [7:0] dat);
    @(posedge clock_in);
    req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    req.rd <= 1'b0;
    #1 dat = rdata;
  endtask : rd
  task cmp_all;
    rd(ADDR_EVENT, v);
    check(v, {6'h00, pf});
    rd(ADDR_A_CADENCE, v);
    check(v, 8'(pr[0]));
    rd(ADDR_B_CADENCE, v);
    check(v, 8'(pr[1]));
    check(8'(seen[0]), 8'(pn[0]));
    check(8'(seen[1]), 8'(pn[1]));
  endtask : cmp_all
  task put(input logic [6:0] la, input logic [6:0] lb);
    gap <= 2'($random(seed));
    lvl[0] <= la;
    lvl[1] <= lb;
    repeat (12) @(posedge clock_in);
    cmp_all;
  endtask : put
  initial begin
    repeat (RUN_CYCLES) @(posedge clock_in);
    fails++;
    end_sim;
  end
  initial begin
    {fails, n_checks} = '0;
    seed = 39;
    req = '0;
    lvl = '{7'h00, 7'h00};
    gap = 2'h0;
    rst_n_in = 1'b0;
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (i = 0; i < 10; i++) begin
      rd(i < 8 ? 9'(9'h010 + i) : 9'(9'h1FF - i), v);
      check(v, 8'h00);
    end
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      w = 8'($random(seed));
      wr(9'(9'h011 + i + i / 2), w);
      rd(9'(9'h011 + i + i / 2), v);
      check(v, {1'b0, w[6:0]});
    end
    $display("test thresholds done");
    wr(ADDR_A_LOW, 8'h14);
    wr(ADDR_A_HIGH, 8'hBF);
    wr(ADDR_B_LOW, 8'h0A);
    wr(ADDR_B_HIGH, 8'h1E);
    wr(ADDR_CONTROL, 8'h03);
    for (i = 0; i < 8; i++) put(SEQ_A[i], SEQ_B[i]);
    $display("test crossings done");
    wr(ADDR_CONTROL, 8'h02);
    rd(ADDR_CONTROL, v);
    check(v, 8'h02);
    put(7'h7F, 7'h00);
    put(7'h00, 7'h7F);
    $display("test disable done");
    wr(ADDR_CONTROL, 8'h03);
    put(7'h00, 7'h00);
    repeat (3000) @(posedge clock_in);
    rd(ADDR_A_CADENCE, v);
    check(v, 8'h7F);
    rd(ADDR_B_CADENCE, v);
    check(v, 8'h7F);
    put(7'h7F, 7'h7F);
    put(7'h00, 7'h00);
    $display("test cadence count done");
    end_sim;
  end
endmodule : energy_detect_cadence_test
`default_nettype wire
